// ==== src/rmsc_pkg.sv ====
// Shared constants and carriers of the radio module sleep controller.
// Assumes a single 100 MHz clock and a host that writes parameters by command.
// Notes on behaviour
// - Selector 0 means no sleep, 1 pin hibernate, 2 pin doze, 3 reserved, 4 cyclic, 5 cyclic with pin wake; reset 0.
// - Selector 6 is accepted as a legacy coordinator setting; otherwise a separate input picks the coordinator role.
// - With option bit 0 clear a cyclic sleeper polls its coordinator on each wake except an association retry wake, with it set the poll is skipped.
// - With option bit 1 clear and sampling enabled one sample is taken on each wake, with it set none is.
// - Sleep follows an idle period of the time-before-sleep value in 1 ms units, range 1 to 0xFFFF, reset 0x1388.
// - The time-before-sleep value is used only while selector 4 or 5 is active.
// - A cyclic end device sleeps for the cyclic period in 10 ms units, range 0 to 0x68B0, reset 0.
// - A coordinator with a non-zero period discards a held indirect message after 2.5 periods undelivered.
// - An unassociated cyclic sleeper set to associate sleeps the disassociated period, 1 to 0x68B0, reset 0x3E8.
package rmsc_pkg;

    // Timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MS_NS          = 1000000;
    localparam int CYC_PER_MS     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MS_PER_SLOT    = 10;
    localparam int HOLD_MS_PER_SP = 25;      // 2.5 periods of 10 ms
    localparam int TMR_W          = 20;

    // Register select codes of the command port
    localparam logic [2:0] SEL_MODE   = 3'h0;
    localparam logic [2:0] SEL_OPTS   = 3'h1;
    localparam logic [2:0] SEL_IDLE   = 3'h2;
    localparam logic [2:0] SEL_PERIOD = 3'h3;
    localparam logic [2:0] SEL_UNASC  = 3'h4;
    localparam logic [2:0] SEL_STATUS = 3'h5;

    // Reset values
    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [7:0]  OPTS_RST   = 8'h00;
    localparam logic [15:0] IDLE_RST   = 16'h1388;
    localparam logic [15:0] PERIOD_RST = 16'h0000;
    localparam logic [15:0] UNASC_RST  = 16'h03E8;

    // Limits
    localparam logic [15:0] MODE_MAX   = 16'h0006;
    localparam logic [15:0] OPTS_MAX   = 16'h0004;
    localparam logic [15:0] IDLE_MIN   = 16'h0001;
    localparam logic [15:0] IDLE_MAX   = 16'hFFFF;
    localparam logic [15:0] PERIOD_MAX = 16'h68B0;
    localparam logic [15:0] UNASC_MIN  = 16'h0001;

    // Selector encodings
    localparam logic [7:0] MODE_NONE   = 8'h00;
    localparam logic [7:0] MODE_HIB    = 8'h01;
    localparam logic [7:0] MODE_DOZE   = 8'h02;
    localparam logic [7:0] MODE_RSVD   = 8'h03;
    localparam logic [7:0] MODE_CYC    = 8'h04;
    localparam logic [7:0] MODE_CYCPIN = 8'h05;
    localparam logic [7:0] MODE_COORD  = 8'h06;

    // Option bit positions
    localparam int OPT_NO_POLL   = 0;
    localparam int OPT_NO_SAMPLE = 1;

    // Status word bit positions
    localparam int ST_ASLEEP  = 0;
    localparam int ST_DOZE    = 1;
    localparam int ST_HIB     = 2;
    localparam int ST_HOLDING = 3;
    localparam int ST_COORD   = 4;

    typedef struct packed {
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
        logic [2:0]  sel;    // Register select
        logic [15:0] wdata;  // Write value
    } rmsc_cmd_t;

    typedef struct packed {
        logic [15:0] data;   // Read value
        logic        valid;  // Read answer pulse
        logic        ack;    // Write accepted pulse
        logic        err;    // Write refused pulse
    } rmsc_rsp_t;

endpackage

// ==== src/rmsc_timer.sv ====
// Loadable down counter that steps on a tick and flags when it reaches zero.
// Assumes load and tick come from logic on the same clock.
`timescale 1ns/1ps
module rmsc_timer #(
    parameter int W = 20
) (
    input  wire logic         clk,      // System clock
    input  wire logic         srst,     // Synchronous reset, high
    input  wire logic         ce,       // Clock enable
    input  wire logic         load,     // Load a new count
    input  wire logic [W-1:0] load_val, // Count to load
    input  wire logic         tick,     // Step pulse
    output logic              expired   // Count is zero
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         zero;
    } rmsc_tmr_st_t;

    rmsc_tmr_st_t s_reg;
    rmsc_tmr_st_t s_next;

    // Load wins over a step so a restart is never shortened
    always_comb begin
        s_next = s_reg;
        if (load) begin
            s_next.cnt = load_val;
        end else if (tick && s_reg.cnt != '0) begin
            s_next.cnt = s_reg.cnt - W'(1);
        end
        s_next.zero = (s_next.cnt == '0);
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '{cnt: '0, zero: 1'b1};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign expired = s_reg.zero;

endmodule // rmsc_timer

// ==== src/rmsc_sleep_ctrl.sv ====
// Sleep controller: parameter store, pin and cyclic sleep sequencing, indirect hold timer.
// Assumes activity and message strobes are same-clock pulses; the sleep pin is asynchronous.
`timescale 1ns/1ps
module rmsc_sleep_ctrl #(
    parameter int CYC_PER_MS = rmsc_pkg::CYC_PER_MS
) (
    input  wire logic               clk,          // 100 MHz clock
    input  wire logic               srst,         // Synchronous reset, high
    input  wire logic               ce,           // Clock enable
    input  wire rmsc_pkg::rmsc_cmd_t cmd,         // Parameter command
    output rmsc_pkg::rmsc_rsp_t     rsp,          // Command answer
    input  wire logic               sleep_pin,    // Sleep request pin, high asks sleep
    input  wire logic               serial_act,   // Serial traffic pulse
    input  wire logic               radio_act,    // Radio traffic pulse
    input  wire logic               coord_sel,    // Coordinator role setting
    input  wire logic               assoc_en,     // Configured to associate
    input  wire logic               associated,   // Currently associated
    input  wire logic               sample_en,    // Any ADC or DIO sampling enabled
    input  wire logic               msg_queued,   // Indirect message stored
    input  wire logic               msg_sent,     // Indirect message delivered
    output logic                    asleep,       // Device asleep
    output logic                    doze,         // Pin doze active
    output logic                    hibernate,    // Pin hibernate active
    output logic                    poll_req,     // Poll coordinator pulse
    output logic                    sample_req,   // Wake sample pulse
    output logic                    assoc_retry,  // Association retry pulse
    output logic                    msg_discard   // Held message dropped pulse
);

    typedef enum logic [3:0] {
        S_AWAKE = 4'b0001,
        S_CYC   = 4'b0010,
        S_PIN   = 4'b0100,
        S_WAKE  = 4'b1000
    } rmsc_state_t;

    typedef struct packed {
        rmsc_state_t         st;
        logic [1:0]          pin_sync;
        logic [31:0]         ms_cnt;
        logic [3:0]          slot_cnt;
        logic                ms_tick;
        logic                slot_tick;
        logic [7:0]          mode;
        logic [7:0]          opts;
        logic [15:0]         idle;
        logic [15:0]         period;
        logic [15:0]         unasc;
        logic                retry_wake;
        logic                holding;
        logic                asleep;
        logic                doze;
        logic                hib;
        logic                poll;
        logic                sample;
        logic                retry;
        logic                discard;
        rmsc_pkg::rmsc_rsp_t rsp;
    } rmsc_sc_st_t;

    rmsc_sc_st_t s_reg;
    rmsc_sc_st_t s_next;

    logic                       idle_load;
    logic                       sleep_load;
    logic                       hold_load;
    logic [rmsc_pkg::TMR_W-1:0] idle_val;
    logic [rmsc_pkg::TMR_W-1:0] sleep_val;
    logic [rmsc_pkg::TMR_W-1:0] hold_val;
    logic                       idle_done;
    logic                       sleep_done;
    logic                       hold_done;
    logic                       cyclic;
    logic                       is_coord;
    logic                       pin_req;
    logic                       activity;
    logic                       ok;

    // Inclusive range test shared by every parameter write
    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction

    // Widen a 16-bit setting to timer width
    function automatic logic [rmsc_pkg::TMR_W-1:0] to_tmr(input logic [15:0] v);
        to_tmr = {{(rmsc_pkg::TMR_W-16){1'b0}}, v};
    endfunction

    // Mode decode
    assign cyclic   = (s_reg.mode == rmsc_pkg::MODE_CYC) || (s_reg.mode == rmsc_pkg::MODE_CYCPIN);
    assign is_coord = coord_sel || (s_reg.mode == rmsc_pkg::MODE_COORD);
    assign pin_req  = s_reg.pin_sync[1];
    assign activity = serial_act || radio_act;

    // Idle timer restarts on traffic and whenever the awake interval begins
    assign idle_load = activity || (s_reg.st != S_AWAKE)
                       || !cyclic;
    assign idle_val  = to_tmr(s_reg.idle);

    // Sleep timer loads on the way into cyclic sleep; an unassociated device set to associate uses its own period
    assign sleep_load = (s_reg.st == S_AWAKE) && cyclic && !is_coord && idle_done;
    assign sleep_val  = (assoc_en && !associated) ? to_tmr(s_reg.unasc) : to_tmr(s_reg.period);

    // Hold timer runs in milliseconds: 25 ms per period unit gives 2.5 periods
    assign hold_load = msg_queued;
    assign hold_val  = rmsc_pkg::TMR_W'(s_reg.period) * rmsc_pkg::TMR_W'(rmsc_pkg::HOLD_MS_PER_SP);

    rmsc_timer #(.W(rmsc_pkg::TMR_W)) u_idle (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .load     (idle_load),
        .load_val (idle_val),
        .tick     (s_reg.ms_tick),
        .expired  (idle_done)
    );

    rmsc_timer #(.W(rmsc_pkg::TMR_W)) u_sleep (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .load     (sleep_load),
        .load_val (sleep_val),
        .tick     (s_reg.slot_tick),
        .expired  (sleep_done)
    );

    rmsc_timer #(.W(rmsc_pkg::TMR_W)) u_hold (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .load     (hold_load),
        .load_val (hold_val),
        .tick     (s_reg.ms_tick),
        .expired  (hold_done)
    );

    // Next-state logic of the whole controller
    always_comb begin
        ok = 1'b0;
        s_next = s_reg;
        s_next.pin_sync = {s_reg.pin_sync[0], sleep_pin};
        s_next.poll = 1'b0;
        s_next.sample = 1'b0;
        s_next.retry = 1'b0;
        s_next.discard = 1'b0;
        s_next.rsp.valid = 1'b0;
        s_next.rsp.ack = 1'b0;
        s_next.rsp.err = 1'b0;

        // Millisecond and 10 ms time base
        s_next.ms_tick = 1'b0;
        s_next.slot_tick = 1'b0;
        if (s_reg.ms_cnt >= 32'(CYC_PER_MS - 1)) begin
            s_next.ms_cnt = '0;
            s_next.ms_tick = 1'b1;
            if (s_reg.slot_cnt >= 4'(rmsc_pkg::MS_PER_SLOT - 1)) begin
                s_next.slot_cnt = '0;
                s_next.slot_tick = 1'b1;
            end else begin
                s_next.slot_cnt = s_reg.slot_cnt + 4'h1;
            end
        end else begin
            s_next.ms_cnt = s_reg.ms_cnt + 32'h1;
        end

        // Parameter writes; out-of-range values are refused and leave the register as it was
        if (cmd.wr) begin
            case (cmd.sel)
                rmsc_pkg::SEL_MODE: begin
                    ok = in_range(cmd.wdata, 16'h0000, rmsc_pkg::MODE_MAX)
                         && cmd.wdata[7:0] != rmsc_pkg::MODE_RSVD;
                    if (ok) s_next.mode = cmd.wdata[7:0];
                end
                rmsc_pkg::SEL_OPTS: begin
                    ok = in_range(cmd.wdata, 16'h0000, rmsc_pkg::OPTS_MAX);
                    if (ok) s_next.opts = cmd.wdata[7:0];
                end
                rmsc_pkg::SEL_IDLE: begin
                    ok = in_range(cmd.wdata, rmsc_pkg::IDLE_MIN, rmsc_pkg::IDLE_MAX);
                    if (ok) s_next.idle = cmd.wdata;
                end
                rmsc_pkg::SEL_PERIOD: begin
                    ok = in_range(cmd.wdata, 16'h0000, rmsc_pkg::PERIOD_MAX);
                    if (ok) s_next.period = cmd.wdata;
                end
                rmsc_pkg::SEL_UNASC: begin
                    ok = in_range(cmd.wdata, rmsc_pkg::UNASC_MIN, rmsc_pkg::PERIOD_MAX);
                    if (ok) s_next.unasc = cmd.wdata;
                end
                default: ok = 1'b0;
            endcase
            s_next.rsp.ack = ok;
            s_next.rsp.err = !ok;
        end

        // Reads answer one cycle later; unknown selects read zero
        if (cmd.rd) begin
            s_next.rsp.valid = 1'b1;
            case (cmd.sel)
                rmsc_pkg::SEL_MODE:   s_next.rsp.data = {8'h00, s_reg.mode};
                rmsc_pkg::SEL_OPTS:   s_next.rsp.data = {8'h00, s_reg.opts};
                rmsc_pkg::SEL_IDLE:   s_next.rsp.data = s_reg.idle;
                rmsc_pkg::SEL_PERIOD: s_next.rsp.data = s_reg.period;
                rmsc_pkg::SEL_UNASC:  s_next.rsp.data = s_reg.unasc;
                rmsc_pkg::SEL_STATUS: begin
                    s_next.rsp.data = 16'h0000;
                    s_next.rsp.data[rmsc_pkg::ST_ASLEEP]  = s_reg.asleep;
                    s_next.rsp.data[rmsc_pkg::ST_DOZE]    = s_reg.doze;
                    s_next.rsp.data[rmsc_pkg::ST_HIB]     = s_reg.hib;
                    s_next.rsp.data[rmsc_pkg::ST_HOLDING] = s_reg.holding;
                    s_next.rsp.data[rmsc_pkg::ST_COORD]   = is_coord;
                end
                default:              s_next.rsp.data = 16'h0000;
            endcase
        end

        // Indirect message hold: only a coordinator with a non-zero period keeps one
        if (msg_queued && is_coord && s_reg.period != 16'h0000) begin
            s_next.holding = 1'b1;
        end else if (msg_sent) begin
            s_next.holding = 1'b0;
        end else if (s_reg.holding && hold_done) begin
            s_next.holding = 1'b0;
            s_next.discard = 1'b1;
        end

        // Sleep sequencing
        case (s_reg.st)
            S_AWAKE: begin
                if ((s_reg.mode == rmsc_pkg::MODE_HIB || s_reg.mode == rmsc_pkg::MODE_DOZE) && pin_req) begin
                    s_next.st = S_PIN;
                end else if (sleep_load) begin
                    s_next.st = S_CYC;
                    s_next.retry_wake = assoc_en && !associated;
                end
            end
            S_CYC: begin
                // Timed wake, early pin wake in mode 5, or leaving cyclic mode
                if (sleep_done || !cyclic
                    || (s_reg.mode == rmsc_pkg::MODE_CYCPIN && !pin_req)) begin
                    s_next.st = S_WAKE;
                end
            end
            S_PIN: begin
                if (!pin_req || (s_reg.mode != rmsc_pkg::MODE_HIB && s_reg.mode != rmsc_pkg::MODE_DOZE)) begin
                    s_next.st = S_WAKE;
                end
            end
            S_WAKE: begin
                s_next.st = S_AWAKE;
                s_next.sample = sample_en && !s_reg.opts[rmsc_pkg::OPT_NO_SAMPLE];
                if (s_reg.retry_wake) begin
                    s_next.retry = 1'b1;
                end else if (cyclic) begin
                    s_next.poll = !s_reg.opts[rmsc_pkg::OPT_NO_POLL];
                end
                s_next.retry_wake = 1'b0;
            end
            default: s_next.st = S_AWAKE;
        endcase

        s_next.asleep = (s_next.st == S_CYC) || (s_next.st == S_PIN);
        s_next.doze   = (s_next.st == S_PIN) && (s_reg.mode == rmsc_pkg::MODE_DOZE);
        s_next.hib    = (s_next.st == S_PIN) && (s_reg.mode == rmsc_pkg::MODE_HIB);
    end

    // State register; clock enable low freezes everything
    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg            <= '0;
            s_reg.st         <= S_AWAKE;
            s_reg.mode       <= rmsc_pkg::MODE_RST;
            s_reg.opts       <= rmsc_pkg::OPTS_RST;
            s_reg.idle       <= rmsc_pkg::IDLE_RST;
            s_reg.period     <= rmsc_pkg::PERIOD_RST;
            s_reg.unasc      <= rmsc_pkg::UNASC_RST;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // All outputs straight from the state register
    assign rsp         = s_reg.rsp;
    assign asleep      = s_reg.asleep;
    assign doze        = s_reg.doze;
    assign hibernate   = s_reg.hib;
    assign poll_req    = s_reg.poll;
    assign sample_req  = s_reg.sample;
    assign assoc_retry = s_reg.retry;
    assign msg_discard = s_reg.discard;

endmodule // rmsc_sleep_ctrl

// ==== verif/rmsc_sleep_ctrl_checker.sv ====
// Port-level assertions of the sleep controller, bound to its top module.
// Assumes one clock domain and the one-cycle answer timing of the command port.
`timescale 1ns/1ps
module rmsc_sleep_ctrl_checker (
    input wire logic                clk,         // Clock
    input wire logic                srst,        // Sync reset
    input wire logic                ce,          // Enable
    input wire rmsc_pkg::rmsc_cmd_t cmd,         // Command
    input wire rmsc_pkg::rmsc_rsp_t rsp,         // Answer
    input wire logic                sample_en,   // Sampling
    input wire logic                asleep,      // Asleep
    input wire logic                doze,        // Doze
    input wire logic                hibernate,   // Hibernate
    input wire logic                poll_req,    // Poll
    input wire logic                sample_req,  // Sample
    input wire logic                assoc_retry, // Retry
    input wire logic                msg_discard  // Drop
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Command answers: each taken access gets exactly one reply next cycle
    chk_wr_answer: assert property (cmd.wr && ce |=> rsp.ack != rsp.err)
        else $error("write not answered once");
    chk_rd_answer: assert property (cmd.rd && ce |=> rsp.valid)
        else $error("read not answered");
    chk_rsvd_mode: assert property (cmd.wr && ce && cmd.sel == 3'h0 && cmd.wdata == 16'h0003 |=> rsp.err)
        else $error("reserved mode accepted");
    chk_legacy_mode: assert property (cmd.wr && ce && cmd.sel == 3'h0 && cmd.wdata == 16'h0006 |=> rsp.ack)
        else $error("legacy mode refused");
    chk_idle_zero: assert property (cmd.wr && ce && cmd.sel == 3'h2 && cmd.wdata == 16'h0000 |=> rsp.err)
        else $error("zero idle time accepted");
    chk_period_max: assert property (cmd.wr && ce && cmd.sel == 3'h3 && cmd.wdata > 16'h68B0 |=> rsp.err)
        else $error("period above maximum accepted");
    // Sleep outputs: pin sleep kinds exclusive, wake pulses only while awake
    chk_pin_kind: assert property ((doze || hibernate) |-> asleep && !(doze && hibernate))
        else $error("pin sleep flags inconsistent");
    chk_wake_awake: assert property ((poll_req || sample_req || assoc_retry) |-> !asleep)
        else $error("wake pulse while asleep");
    chk_retry_no_poll: assert property (assoc_retry |-> !poll_req)
        else $error("retry wake also polled");
    chk_sample_gate: assert property (sample_req |-> sample_en)
        else $error("sample without sampling enabled");
    cover property (asleep && !doze && !hibernate);
    cover property (msg_discard);
    cover property (assoc_retry);
endmodule // rmsc_sleep_ctrl_checker

bind rmsc_sleep_ctrl rmsc_sleep_ctrl_checker chk_u (
    .clk(clk), .srst(srst), .ce(ce), .cmd(cmd), .rsp(rsp), .sample_en(sample_en),
    .asleep(asleep), .doze(doze), .hibernate(hibernate), .poll_req(poll_req),
    .sample_req(sample_req), .assoc_retry(assoc_retry), .msg_discard(msg_discard));

// ==== verif/rmsc_peer.sv ====
// Peer coordinator model: answers a data poll with one radio frame.
// Assumes the poll pulse is on the same clock.
`timescale 1ns/1ps
module rmsc_peer #(
    parameter int DLY = 3
) (
    input  wire logic clk,       // Clock
    input  wire logic srst,      // Sync reset
    input  wire logic poll_req,  // Device polls
    input  wire logic has_data,  // Data pending here
    output logic      radio_act  // Frame to device
);
    logic [3:0] wait_reg;
    // A poll with data pending is answered after a turnaround, never at once
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_reg  <= 4'h0;
            radio_act <= 1'b0;
        end else begin
            radio_act <= (wait_reg == 4'h1);
            if (poll_req && has_data) begin
                wait_reg <= 4'(DLY);
            end else if (wait_reg != 4'h0) begin
                wait_reg <= wait_reg - 4'h1;
            end
        end
    end
endmodule // rmsc_peer

// ==== verif/rmsc_sleep_ctrl_tb.sv ====
// Self-checking bench of the sleep controller with a peer coordinator model.
// Assumes a shortened millisecond of CPM cycles.
`timescale 1ns/1ps
module rmsc_sleep_ctrl_tb;
    localparam int CPM = 10;
    logic                clk = 1'b0;
    logic                srst = 1'b1;
    rmsc_pkg::rmsc_cmd_t cmd = '0;
    rmsc_pkg::rmsc_rsp_t rsp;
    logic                sleep_pin = 1'b0, serial_act = 1'b0, assoc_en = 1'b0, associated = 1'b1;
    logic                msg_queued = 1'b0, msg_sent = 1'b0, has_data = 1'b1;
    logic                radio_act, asleep, doze, hibernate, poll_req, sample_req, assoc_retry, msg_discard;
    int                  bad_count = 0;
    int                  samples_checked = 0;

    rmsc_sleep_ctrl #(.CYC_PER_MS(CPM)) dut_u (
        .clk(clk), .srst(srst), .ce(1'b1), .cmd(cmd), .rsp(rsp), .sleep_pin(sleep_pin),
        .serial_act(serial_act), .radio_act(radio_act), .coord_sel(1'b0), .assoc_en(assoc_en),
        .associated(associated), .sample_en(1'b1), .msg_queued(msg_queued), .msg_sent(msg_sent),
        .asleep(asleep), .doze(doze), .hibernate(hibernate), .poll_req(poll_req),
        .sample_req(sample_req), .assoc_retry(assoc_retry), .msg_discard(msg_discard));
    rmsc_peer peer_u (.clk(clk), .srst(srst), .poll_req(poll_req), .has_data(has_data), .radio_act(radio_act));

    // Clock, 10 ns period
    initial begin
        forever #5 clk = ~clk;
    end

    // Inputs change 1 ns after the rising edge, outputs are read there too
    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk16(logic [15:0] got, logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Cycle counts are judged against a window, since tick phase is free
    task automatic chk_in(int got, int lo, int hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic access(logic wr, logic [2:0] sel, logic [15:0] d, output rmsc_pkg::rmsc_rsp_t r);
        cmd = {wr, !wr, sel, d};
        tick();
        r = rsp;
        cmd = '0;
        tick();
    endtask

    task automatic wrt(logic [2:0] sel, logic [15:0] d, logic e);
        rmsc_pkg::rmsc_rsp_t r;
        access(1'b1, sel, d, r);
        chk16({14'h0, r.ack, r.err}, {14'h0, !e, e});
    endtask

    task automatic rdc(logic [2:0] sel, logic [15:0] exp);
        rmsc_pkg::rmsc_rsp_t r;
        access(1'b0, sel, 16'h0000, r);
        chk16({15'h0, r.valid}, 16'h0001);
        chk16(r.data, exp);
    endtask

    task automatic t_reset();
        rdc(rmsc_pkg::SEL_MODE, 16'h0000);
        rdc(rmsc_pkg::SEL_OPTS, 16'h0000);
        rdc(rmsc_pkg::SEL_IDLE, 16'h1388);
        rdc(rmsc_pkg::SEL_PERIOD, 16'h0000);
        rdc(rmsc_pkg::SEL_UNASC, 16'h03E8);
    endtask

    // Limits of every setting; readback where taken
    task automatic t_ranges();
        logic [2:0]  s [14] = '{0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 4, 4, 5, 6};
        logic [15:0] d [14] = '{3, 7, 6, 5, 5, 4, 0, 16'hFFFF, 16'h68B1, 16'h68B0, 0, 16'h68B0, 0, 0};
        logic        e [14] = '{1, 1, 0, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 1};
        for (int i = 0; i < 14; i++) begin
            wrt(s[i], d[i], e[i]);
            if (!e[i]) begin
                rdc(s[i], d[i]);
            end
        end
        wrt(rmsc_pkg::SEL_MODE, 16'h0000, 1'b0);
    endtask

    // Pin sleep: mode 0 ignores the pin, 1 hibernates, 2 dozes
    task automatic t_pin();
        logic [2:0] pe [3] = '{3'b000, 3'b101, 3'b110};
        for (int m = 0; m < 3; m++) begin
            wrt(rmsc_pkg::SEL_MODE, 16'(m), 1'b0);
            sleep_pin = 1'b1;
            tick(6);
            chk16({13'h0, asleep, doze, hibernate}, {13'h0, pe[m]});
            sleep_pin = 1'b0;
            tick(6);
            chk16({13'h0, asleep, doze, hibernate}, 16'h0000);
        end
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask

    // One cyclic sleep: idle wait, sleep length and wake pulses {retry, sample, poll}
    task automatic t_cyclic(logic [7:0] mode, logic [7:0] opts, logic ua, logic [2:0] exp);
        int         ic = 0, sc = 0;
        logic [2:0] seen = 3'b000;
        wrt(rmsc_pkg::SEL_MODE, 16'h0000, 1'b0);
        assoc_en = ua;
        associated = !ua;
        sleep_pin = (mode == 8'h05);
        wrt(rmsc_pkg::SEL_IDLE, 16'h0002, 1'b0);
        wrt(rmsc_pkg::SEL_PERIOD, ua ? 16'h0001 : 16'h0003, 1'b0);
        wrt(rmsc_pkg::SEL_UNASC, ua ? 16'h0003 : 16'h0001, 1'b0);
        wrt(rmsc_pkg::SEL_OPTS, {8'h00, opts}, 1'b0);
        wrt(rmsc_pkg::SEL_MODE, {8'h00, mode}, 1'b0);
        pulse(serial_act);
        while (!asleep && ic < 3000) begin
            tick();
            ic++;
        end
        while (asleep && sc < 3000) begin
            tick();
            sc++;
        end
        repeat (6) begin
            seen |= {assoc_retry, sample_req, poll_req};
            tick();
        end
        chk_in(ic, CPM, 2 * CPM + 8);
        chk_in(sc, 20 * CPM, 30 * CPM + 8);
        chk16({13'h0, seen}, {13'h0, exp});
        assoc_en = 1'b0;
        associated = 1'b1;
        sleep_pin = 1'b0;
    endtask

    // Traffic keeps a cyclic sleeper awake; in mode 0 it never sleeps
    task automatic t_activity();
        wrt(rmsc_pkg::SEL_MODE, 16'h0004, 1'b0);
        repeat (12) begin
            pulse(serial_act);
            tick(6);
            chk16({15'h0, asleep}, 16'h0000);
        end
        wrt(rmsc_pkg::SEL_MODE, 16'h0000, 1'b0);
        tick(80);
        chk16({15'h0, asleep}, 16'h0000);
    endtask

    // Legacy coordinator: held message dropped after 2.5 periods, delivery cancels the drop
    task automatic t_hold();
        int n = 0;
        wrt(rmsc_pkg::SEL_MODE, 16'h0006, 1'b0);
        wrt(rmsc_pkg::SEL_PERIOD, 16'h0001, 1'b0);
        pulse(msg_queued);
        while (!msg_discard && n < 1000) begin
            tick();
            n++;
        end
        chk_in(n, 25 * CPM - 10, 25 * CPM + 8);
        chk16({15'h0, asleep}, 16'h0000);
        pulse(msg_queued);
        rdc(rmsc_pkg::SEL_STATUS, 16'h0018);
        tick(18);
        pulse(msg_sent);
        n = 0;
        repeat (400) begin
            n += msg_discard;
            tick();
        end
        chk_in(n, 0, 0);
    endtask

    task automatic summarize();
        $display("checks=%0d bad=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard, far beyond the test length
    initial begin
        #(10 * 40000);
        bad_count++;
        summarize();
    end

    // Main sequence
    initial begin
        tick(20);
        srst = 1'b0;
        t_reset();
        t_ranges();
        t_pin();
        t_cyclic(8'h04, 8'h00, 1'b0, 3'b011);
        t_cyclic(8'h04, 8'h03, 1'b0, 3'b000);
        t_cyclic(8'h05, 8'h01, 1'b0, 3'b010);
        t_cyclic(8'h04, 8'h00, 1'b1, 3'b110);
        t_activity();
        t_hold();
        summarize();
    end
endmodule // rmsc_sleep_ctrl_tb
